// *** scpi_status_map.svh ***
// Width, field positions, reset values and masks of the status block.
`ifndef SCPI_STATUS_MAP_SVH
`define SCPI_STATUS_MAP_SVH

`define SCPI_REG_W          16
`define SCPI_PTR_RESET      16'hFFFF
`define SCPI_ZERO_RESET     16'h0000
`define SCPI_OPERATION_SUMMARY_USED_MASK 16'h3720
`define SCPI_OPERATION_SUMMARY_INST_BIT  13
`define SCPI_OPERATION_SUMMARY_ZERO_BIT  15
`define SCPI_INST_USED_MASK 16'h000F
`define SCPI_ESR_USED_MASK  8'hBD
`define SCPI_STB_QUEUE_BIT  2
`define SCPI_STB_QUESTIONABLE_SUMMARY_BIT   3
`define SCPI_STB_RESP_BIT   4
`define SCPI_STB_ESR_BIT    5
`define SCPI_STB_MSS_BIT    6
`define SCPI_STB_OPERATION_SUMMARY_BIT   7

`endif

// *** scpi_status_pkg.sv ***
// Types shared by the status block: command groups, fields and state.
`default_nettype none
package scpi_status_pkg;

    // Which status structure a command addresses.
    typedef enum logic [2:0] {
        GRP_OPERATION,
        GRP_INSTRUMENT,
        GRP_QUESTIONABLE,
        GRP_CHANNEL,
        GRP_STD_EVENT,
        GRP_SRV_ENABLE,
        GRP_STATUS_BYTE
    } grp_t;

    // Which sub-register of a group a command addresses.
    typedef enum logic [2:0] {
        FLD_EVENT,
        FLD_COND,
        FLD_ENABLE,
        FLD_PTR,
        FLD_NTR
    } fld_t;

    // State of one SCPI status register.
    typedef struct packed {
        logic [15:0] cond_q;
        logic [15:0] evt;
        logic [15:0] en;
        logic [15:0] ptr;
        logic [15:0] ntr;
    } sreg_state_t;

    // State of the status-byte level of the block.
    typedef struct packed {
        logic [7:0]  esr;
        logic [7:0]  ese;
        logic [7:0]  sre;
        logic [15:0] rsp_data;
        logic        rsp_valid;
        logic [15:0] poll_data;
        logic        poll_valid;
    } top_state_t;

endpackage

`default_nettype wire

// *** scpi_status_reg.sv ***
// One SCPI status register: condition, filters, latched event and enable.
`timescale 1ns/1ps
`default_nettype none
`include "scpi_status_map.svh"

module scpi_status_reg (
    input  wire logic                  clock_i,
    input  wire logic                  sys_rst_i,
    input  wire logic [15:0]           cond_i,
    input  wire logic                  wr_i,
    input  wire scpi_status_pkg::fld_t field_i,
    input  wire logic [15:0]           wdata_i,
    input  wire logic                  evt_rd_i,
    output logic      [15:0]           evt_o,
    output logic      [15:0]           en_o,
    output logic      [15:0]           ptr_o,
    output logic      [15:0]           ntr_o,
    output logic                       summary_o
);

    scpi_status_pkg::sreg_state_t st_ff;
    scpi_status_pkg::sreg_state_t nxt_st;
    logic [15:0]                  rise;
    logic [15:0]                  fall;
    logic [15:0]                  hit;

    ////////////////////////////////////////////////////////////////////////
    // Edge detection against the previous condition, gated by the filters.
    // Both filters set report either edge; both clear report nothing.
    assign rise = cond_i & ~st_ff.cond_q;
    assign fall = ~cond_i & st_ff.cond_q;
    assign hit  = (rise & st_ff.ptr) | (fall & st_ff.ntr);

    ////////////////////////////////////////////////////////////////////////
    // Next state: a new edge wins over a clearing read in the same cycle.
    always_comb begin
        nxt_st        = st_ff;
        nxt_st.cond_q = cond_i;
        nxt_st.evt    = (st_ff.evt & ~{16{evt_rd_i}}) | hit;
        if (wr_i) begin
            case (field_i)
                scpi_status_pkg::FLD_ENABLE: nxt_st.en  = wdata_i;
                scpi_status_pkg::FLD_PTR:    nxt_st.ptr = wdata_i;
                scpi_status_pkg::FLD_NTR:    nxt_st.ntr = wdata_i;
                default:                     nxt_st.en  = st_ff.en;
            endcase
        end
    end

    // Reset clears everything but the rising filter, which opens fully.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st_ff.cond_q <= `SCPI_ZERO_RESET;
            st_ff.evt    <= `SCPI_ZERO_RESET;
            st_ff.en     <= `SCPI_ZERO_RESET;
            st_ff.ptr    <= `SCPI_PTR_RESET;
            st_ff.ntr    <= `SCPI_ZERO_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Summary follows the stored event and enable without extra delay.
    assign evt_o     = st_ff.evt;
    assign en_o      = st_ff.en;
    assign ptr_o     = st_ff.ptr;
    assign ntr_o     = st_ff.ntr;
    assign summary_o = |(st_ff.evt & st_ff.en);

endmodule

`default_nettype wire

// *** scpi_status_top.sv ***
// Status-reporting core: SCPI registers, standard events and status byte.
`timescale 1ns/1ps
`default_nettype none
`include "scpi_status_map.svh"

module scpi_status_top #(
    parameter int NUM_CH = 4,
    parameter int CH_W   = 2
) (
    input  wire logic                    clock_i,
    input  wire logic                    sys_rst_i,
    input  wire logic [15:0]             operation_cond_i,
    input  wire logic [15:0]             questionable_cond_i,
    input  wire logic [NUM_CH*16-1:0]    chan_cond_i,
    input  wire logic [7:0]              std_event_i,
    input  wire logic                    queue_not_empty_i,
    input  wire logic                    response_available_i,
    input  wire logic                    cmd_valid_i,
    input  wire logic                    cmd_write_i,
    input  wire scpi_status_pkg::grp_t   cmd_group_i,
    input  wire scpi_status_pkg::fld_t   cmd_field_i,
    input  wire logic [CH_W-1:0]         cmd_chan_i,
    input  wire logic [15:0]             cmd_wdata_i,
    input  wire logic                    poll_i,
    output logic      [15:0]             rsp_data_o,
    output logic                         rsp_valid_o,
    output logic      [15:0]             poll_data_o,
    output logic                         poll_valid_o,
    output logic      [15:0]             status_summary_byte_o,
    output logic                         srq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    scpi_status_pkg::top_state_t st_ff;
    scpi_status_pkg::top_state_t nxt_st;

    logic [15:0] op_cond;
    logic [15:0] op_evt;
    logic [15:0] op_en;
    logic [15:0] op_ptr;
    logic [15:0] op_ntr;
    logic        op_sum;
    logic [15:0] in_cond;
    logic [15:0] in_evt;
    logic [15:0] in_en;
    logic [15:0] in_ptr;
    logic [15:0] in_ntr;
    logic        in_sum;
    logic [15:0] qu_evt;
    logic [15:0] qu_en;
    logic [15:0] qu_ptr;
    logic [15:0] qu_ntr;
    logic        qu_sum;
    logic [15:0] ch_evt [NUM_CH];
    logic [15:0] ch_en  [NUM_CH];
    logic [15:0] ch_ptr [NUM_CH];
    logic [15:0] ch_ntr [NUM_CH];
    logic [NUM_CH-1:0] ch_sum;
    logic        cmd_rd;
    logic        cmd_wr;
    logic        evt_rd;
    logic [7:0]  stb_core;
    logic        mss;
    logic [15:0] stb_word;

    ////////////////////////////////////////////////////////////////////////
    // Picks one sub-register of a SCPI structure for a read.
    function automatic logic [15:0] pick(
        input scpi_status_pkg::fld_t f,
        input logic [15:0]           c,
        input logic [15:0]           e,
        input logic [15:0]           en,
        input logic [15:0]           p,
        input logic [15:0]           n
    );
        logic [15:0] r;
        r = 16'h0000;
        case (f)
            scpi_status_pkg::FLD_EVENT:  r = e;
            scpi_status_pkg::FLD_COND:   r = c;
            scpi_status_pkg::FLD_ENABLE: r = en;
            scpi_status_pkg::FLD_PTR:    r = p;
            scpi_status_pkg::FLD_NTR:    r = n;
            default:                     r = 16'h0000;
        endcase
        return r;
    endfunction

    // Strobes decoded from the command port.
    assign cmd_rd = cmd_valid_i & ~cmd_write_i;
    assign cmd_wr = cmd_valid_i & cmd_write_i;
    assign evt_rd = cmd_rd & (cmd_field_i == scpi_status_pkg::FLD_EVENT);

    ////////////////////////////////////////////////////////////////////////
    // Condition words. Unused operation bits are masked so they never fire,
    // and bit 15 is held low whatever the input carries.
    assign op_cond = (operation_cond_i & `SCPI_OPERATION_SUMMARY_USED_MASK
                      & ~(16'h0001 << `SCPI_OPERATION_SUMMARY_ZERO_BIT)
                      & ~(16'h0001 << `SCPI_OPERATION_SUMMARY_INST_BIT))
                   | ({15'h0000, in_sum} << `SCPI_OPERATION_SUMMARY_INST_BIT);
    assign in_cond = {{(16 - NUM_CH){1'b0}}, ch_sum} & `SCPI_INST_USED_MASK;

    ////////////////////////////////////////////////////////////////////////
    // The same status register structure serves the operation, instrument, questionable and channel levels.
    scpi_status_reg u_operation (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .cond_i    (op_cond),
        .wr_i      (cmd_wr & (cmd_group_i == scpi_status_pkg::GRP_OPERATION)),
        .field_i   (cmd_field_i),
        .wdata_i   (cmd_wdata_i),
        .evt_rd_i  (evt_rd & (cmd_group_i == scpi_status_pkg::GRP_OPERATION)),
        .evt_o     (op_evt),
        .en_o      (op_en),
        .ptr_o     (op_ptr),
        .ntr_o     (op_ntr),
        .summary_o (op_sum)
    );

    scpi_status_reg u_instrument (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .cond_i    (in_cond),
        .wr_i      (cmd_wr & (cmd_group_i == scpi_status_pkg::GRP_INSTRUMENT)),
        .field_i   (cmd_field_i),
        .wdata_i   (cmd_wdata_i),
        .evt_rd_i  (evt_rd & (cmd_group_i == scpi_status_pkg::GRP_INSTRUMENT)),
        .evt_o     (in_evt),
        .en_o      (in_en),
        .ptr_o     (in_ptr),
        .ntr_o     (in_ntr),
        .summary_o (in_sum)
    );

    scpi_status_reg u_questionable (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .cond_i    (questionable_cond_i),
        .wr_i      (cmd_wr
                    & (cmd_group_i == scpi_status_pkg::GRP_QUESTIONABLE)),
        .field_i   (cmd_field_i),
        .wdata_i   (cmd_wdata_i),
        .evt_rd_i  (evt_rd
                    & (cmd_group_i == scpi_status_pkg::GRP_QUESTIONABLE)),
        .evt_o     (qu_evt),
        .en_o      (qu_en),
        .ptr_o     (qu_ptr),
        .ntr_o     (qu_ntr),
        .summary_o (qu_sum)
    );

    // One summary register per channel, selected by the channel index.
    for (genvar k = 0; k < NUM_CH; k++) begin : g_chan
        logic sel;
        assign sel = (cmd_group_i == scpi_status_pkg::GRP_CHANNEL)
                   & (cmd_chan_i == CH_W'(k));
        scpi_status_reg u_chan (
            .clock_i   (clock_i),
            .sys_rst_i (sys_rst_i),
            .cond_i    (chan_cond_i[k*16 +: 16]),
            .wr_i      (cmd_wr & sel),
            .field_i   (cmd_field_i),
            .wdata_i   (cmd_wdata_i),
            .evt_rd_i  (evt_rd & sel),
            .evt_o     (ch_evt[k]),
            .en_o      (ch_en[k]),
            .ptr_o     (ch_ptr[k]),
            .ntr_o     (ch_ntr[k]),
            .summary_o (ch_sum[k])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Status byte, built combinationally so it tracks every source at once.
    always_comb begin
        stb_core                       = 8'h00;
        stb_core[`SCPI_STB_QUEUE_BIT]  = queue_not_empty_i;
        stb_core[`SCPI_STB_QUESTIONABLE_SUMMARY_BIT]   = qu_sum;
        stb_core[`SCPI_STB_RESP_BIT]   = response_available_i;
        stb_core[`SCPI_STB_ESR_BIT]    = |st_ff.esr;
        stb_core[`SCPI_STB_OPERATION_SUMMARY_BIT]   = op_sum;
    end

    // Bit 6 is excluded from its own enable so the summary cannot hold itself.
    assign mss = |(stb_core & st_ff.sre
                   & ~(8'h01 << `SCPI_STB_MSS_BIT));
    assign stb_word = {8'h00, stb_core
                       | ({7'h00, mss} << `SCPI_STB_MSS_BIT)};

    ////////////////////////////////////////////////////////////////////////
    // Standard events, enables, read responses and serial poll.
    always_comb begin
        nxt_st            = st_ff;
        nxt_st.rsp_valid  = 1'b0;
        nxt_st.poll_valid = 1'b0;
        // A read of the standard event register clears it; new events win.
        if (cmd_rd && cmd_group_i == scpi_status_pkg::GRP_STD_EVENT
            && cmd_field_i == scpi_status_pkg::FLD_EVENT) begin
            nxt_st.esr = 8'h00;
        end
        nxt_st.esr = nxt_st.esr | (std_event_i & `SCPI_ESR_USED_MASK);
        if (cmd_wr) begin
            case (cmd_group_i)
                scpi_status_pkg::GRP_STD_EVENT: begin
                    if (cmd_field_i == scpi_status_pkg::FLD_ENABLE) begin
                        nxt_st.ese = cmd_wdata_i[7:0];
                    end
                end
                scpi_status_pkg::GRP_SRV_ENABLE: begin
                    nxt_st.sre = cmd_wdata_i[7:0];
                end
                default: begin
                    nxt_st.sre = st_ff.sre;
                end
            endcase
        end
        if (cmd_rd) begin
            nxt_st.rsp_valid = 1'b1;
            case (cmd_group_i)
                scpi_status_pkg::GRP_OPERATION:
                    nxt_st.rsp_data = pick(cmd_field_i, op_cond, op_evt,
                                           op_en, op_ptr, op_ntr);
                scpi_status_pkg::GRP_INSTRUMENT:
                    nxt_st.rsp_data = pick(cmd_field_i, in_cond, in_evt,
                                           in_en, in_ptr, in_ntr);
                scpi_status_pkg::GRP_QUESTIONABLE:
                    nxt_st.rsp_data = pick(cmd_field_i, questionable_cond_i,
                                           qu_evt, qu_en, qu_ptr, qu_ntr);
                scpi_status_pkg::GRP_CHANNEL:
                    nxt_st.rsp_data = pick(cmd_field_i,
                                           chan_cond_i[cmd_chan_i*16 +: 16],
                                           ch_evt[cmd_chan_i],
                                           ch_en[cmd_chan_i],
                                           ch_ptr[cmd_chan_i],
                                           ch_ntr[cmd_chan_i]);
                scpi_status_pkg::GRP_STD_EVENT: begin
                    if (cmd_field_i == scpi_status_pkg::FLD_ENABLE) begin
                        nxt_st.rsp_data = {8'h00, st_ff.ese};
                    end else begin
                        nxt_st.rsp_data = {8'h00, st_ff.esr};
                    end
                end
                scpi_status_pkg::GRP_SRV_ENABLE:
                    nxt_st.rsp_data = {8'h00, st_ff.sre};
                // The query only samples; nothing feeding the byte changes.
                scpi_status_pkg::GRP_STATUS_BYTE:
                    nxt_st.rsp_data = stb_word;
                default:
                    nxt_st.rsp_data = 16'h0000;
            endcase
        end
        // Bit 6 of the poll answer is the pending request flag.
        if (poll_i) begin
            nxt_st.poll_valid = 1'b1;
            nxt_st.poll_data  = stb_word;
        end
    end

    // Single register stage for all top-level state.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            st_ff.esr        <= 8'h00;
            st_ff.ese        <= 8'h00;
            st_ff.sre        <= 8'h00;
            st_ff.rsp_data   <= 16'h0000;
            st_ff.rsp_valid  <= 1'b0;
            st_ff.poll_data  <= 16'h0000;
            st_ff.poll_valid <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign rsp_data_o            = st_ff.rsp_data;
    assign rsp_valid_o           = st_ff.rsp_valid;
    assign poll_data_o           = st_ff.poll_data;
    assign poll_valid_o          = st_ff.poll_valid;
    assign status_summary_byte_o = stb_word;
    assign srq_o                 = mss;

endmodule

`default_nettype wire

// *** scpi_status_monitor.sv ***
// Assertion checker watching the ports of the status-reporting core.
`timescale 1ns/1ps
`default_nettype none

module scpi_status_monitor #(
    parameter int NUM_CH = 4,
    parameter int CH_W   = 2
) (
    input wire logic                  clock_i,
    input wire logic                  sys_rst_i,
    input wire logic [15:0]           operation_cond_i,
    input wire logic [15:0]           questionable_cond_i,
    input wire logic [NUM_CH*16-1:0]  chan_cond_i,
    input wire logic [7:0]            std_event_i,
    input wire logic                  queue_not_empty_i,
    input wire logic                  response_available_i,
    input wire logic                  cmd_valid_i,
    input wire logic                  cmd_write_i,
    input wire scpi_status_pkg::grp_t cmd_group_i,
    input wire scpi_status_pkg::fld_t cmd_field_i,
    input wire logic [CH_W-1:0]       cmd_chan_i,
    input wire logic [15:0]           cmd_wdata_i,
    input wire logic                  poll_i,
    input wire logic [15:0]           rsp_data_o,
    input wire logic                  rsp_valid_o,
    input wire logic [15:0]           poll_data_o,
    input wire logic                  poll_valid_o,
    input wire logic [15:0]           status_summary_byte_o,
    input wire logic                  srq_o
);
    ////////////////////////////////////////////////////////////////////////
    // One clock domain, so clocking and reset are given once.
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_read;
        cmd_valid_i && !cmd_write_i;
    endsequence
    sequence s_poll;
        poll_i;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    // Answers come one edge after the request; a read answer never comes unasked.
    property p_read_ans;
        s_read |=> rsp_valid_o;
    endproperty
    a_read_ans: assert property (p_read_ans)
        else $error("read got no answer");
    property p_ans_cause;
        rsp_valid_o |-> $past(cmd_valid_i && !cmd_write_i);
    endproperty
    a_ans_cause: assert property (p_ans_cause)
        else $error("answer without a read");
    property p_poll_ans;
        s_poll |=> poll_valid_o && poll_data_o == $past(status_summary_byte_o);
    endproperty
    a_poll_ans: assert property (p_poll_ans)
        else $error("poll answer differs from status byte");

    ////////////////////////////////////////////////////////////////////////
    // Live bits of the status byte; bit 6 is mirrored on the request line.
    property p_reserved;
        status_summary_byte_o[1:0] == 2'h0 && status_summary_byte_o[15:8] == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved status bits set");
    property p_queue;
        status_summary_byte_o[2] == queue_not_empty_i;
    endproperty
    a_queue: assert property (p_queue)
        else $error("queue bit wrong");
    property p_resp;
        status_summary_byte_o[4] == response_available_i;
    endproperty
    a_resp: assert property (p_resp)
        else $error("response bit wrong");
    property p_srq;
        srq_o == status_summary_byte_o[6];
    endproperty
    a_srq: assert property (p_srq)
        else $error("request line disagrees with bit 6");
    property p_reset;
        $fell(sys_rst_i) |-> !srq_o && !poll_valid_o && !rsp_valid_o;
    endproperty
    a_reset: assert property (p_reset)
        else $error("outputs not idle after reset");
endmodule

bind scpi_status_top scpi_status_monitor #(.NUM_CH(NUM_CH), .CH_W(CH_W)) mon (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .operation_cond_i(operation_cond_i),
    .questionable_cond_i(questionable_cond_i),
    .chan_cond_i(chan_cond_i), .std_event_i(std_event_i),
    .queue_not_empty_i(queue_not_empty_i),
    .response_available_i(response_available_i),
    .cmd_valid_i(cmd_valid_i), .cmd_write_i(cmd_write_i),
    .cmd_group_i(cmd_group_i), .cmd_field_i(cmd_field_i),
    .cmd_chan_i(cmd_chan_i), .cmd_wdata_i(cmd_wdata_i), .poll_i(poll_i),
    .rsp_data_o(rsp_data_o), .rsp_valid_o(rsp_valid_o),
    .poll_data_o(poll_data_o), .poll_valid_o(poll_valid_o),
    .status_summary_byte_o(status_summary_byte_o), .srq_o(srq_o));
`default_nettype wire

// *** host_ctrl.sv ***
// Remote host controller model that performs serial polls.
`timescale 1ns/1ps
`default_nettype none

module host_ctrl (
    input  wire logic        clock_i,
    input  wire logic [15:0] poll_data_i,
    input  wire logic        poll_valid_i,
    output logic             poll_o
);
    // The strobe idles low so no poll is seen before the first request.
    initial poll_o = 1'b0;

    // A one-cycle strobe; the answer is taken one edge later or not at all.
    task automatic serial_poll(output logic [15:0] sb);
        @(posedge clock_i);
        poll_o <= 1'b1;
        @(posedge clock_i);
        poll_o <= 1'b0;
        #1;
        sb = poll_valid_i ? poll_data_i : 16'hXXXX;
    endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench for the status-reporting core.
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam scpi_status_pkg::grp_t GO = scpi_status_pkg::GRP_OPERATION;
    localparam scpi_status_pkg::grp_t GI = scpi_status_pkg::GRP_INSTRUMENT;
    localparam scpi_status_pkg::grp_t GQ = scpi_status_pkg::GRP_QUESTIONABLE;
    localparam scpi_status_pkg::grp_t GC = scpi_status_pkg::GRP_CHANNEL;
    localparam scpi_status_pkg::grp_t GS = scpi_status_pkg::GRP_STD_EVENT;
    localparam scpi_status_pkg::grp_t GE = scpi_status_pkg::GRP_SRV_ENABLE;
    localparam scpi_status_pkg::grp_t GB = scpi_status_pkg::GRP_STATUS_BYTE;
    localparam scpi_status_pkg::fld_t FE = scpi_status_pkg::FLD_EVENT;
    localparam scpi_status_pkg::fld_t FC = scpi_status_pkg::FLD_COND;
    localparam scpi_status_pkg::fld_t FN = scpi_status_pkg::FLD_ENABLE;
    localparam scpi_status_pkg::fld_t FP = scpi_status_pkg::FLD_PTR;
    localparam scpi_status_pkg::fld_t FT = scpi_status_pkg::FLD_NTR;

    logic                  clock_i, sys_rst_i, qne, rav, cv, cw, poll;
    logic                  rv, pv, srq;
    logic [15:0]           op_c, q_c, wd, rd, pd, sb, r;
    logic [63:0]           ch_c;
    logic [7:0]            sev;
    logic [1:0]            chan;
    scpi_status_pkg::grp_t grp;
    scpi_status_pkg::fld_t fld;
    int                    n_errors, checks_done;

    scpi_status_top dut (
        .clock_i(clock_i), .sys_rst_i(sys_rst_i), .operation_cond_i(op_c),
        .questionable_cond_i(q_c), .chan_cond_i(ch_c), .std_event_i(sev),
        .queue_not_empty_i(qne), .response_available_i(rav),
        .cmd_valid_i(cv), .cmd_write_i(cw), .cmd_group_i(grp),
        .cmd_field_i(fld), .cmd_chan_i(chan), .cmd_wdata_i(wd),
        .poll_i(poll), .rsp_data_o(rd), .rsp_valid_o(rv),
        .poll_data_o(pd), .poll_valid_o(pv),
        .status_summary_byte_o(sb), .srq_o(srq));
    host_ctrl host (.clock_i(clock_i), .poll_data_i(pd),
                    .poll_valid_i(pv), .poll_o(poll));

    ////////////////////////////////////////////////////////////////////////
    // Comparison, command and wait helpers.
    task automatic chk(string n, logic [15:0] e, logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmd(input logic w, input scpi_status_pkg::grp_t g,
                       input scpi_status_pkg::fld_t f, input logic [15:0] d);
        @(posedge clock_i);
        cv <= 1'b1;
        cw <= w;
        grp <= g;
        fld <= f;
        wd <= d;
        @(posedge clock_i);
        cv <= 1'b0;
        #1;
        r = rd;
        if (!w) chk("answer strobe", 16'h0001, {15'h0000, rv});
    endtask
    task automatic rc(scpi_status_pkg::grp_t g, scpi_status_pkg::fld_t f,
                      logic [15:0] e, string n);
        cmd(1'b0, g, f, 16'h0000);
        chk(n, e, r);
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios, each judging its own outcome.
    task automatic t_filters();
        rc(GQ, FP, 16'hFFFF, "rise filter reset");
        rc(GQ, FT, 16'h0000, "fall filter reset");
        cmd(1'b1, GQ, FP, 16'h0005);
        cmd(1'b1, GQ, FT, 16'h0006);
        @(posedge clock_i) q_c <= 16'h000F;
        tick(3);
        rc(GQ, FE, 16'h0005, "rising events");
        rc(GQ, FE, 16'h0000, "event after read");
        rc(GQ, FC, 16'h000F, "condition");
        rc(GQ, FC, 16'h000F, "condition again");
        @(posedge clock_i) q_c <= 16'h0000;
        tick(3);
        rc(GQ, FE, 16'h0006, "falling events");
    endtask
    task automatic t_service();
        @(posedge clock_i) q_c <= 16'h0001;
        cmd(1'b1, GQ, FN, 16'h0002);
        chk("masked summary", 16'h0000, sb);
        cmd(1'b1, GQ, FN, 16'h0001);
        chk("enabled summary", 16'h0008, sb);
        cmd(1'b1, GE, FN, 16'h0008);
        chk("master summary", 16'h0048, sb);
        chk("request line", 16'h0001, {15'h0000, srq});
        rc(GB, FE, 16'h0048, "byte query");
        chk("byte after query", 16'h0048, sb);
        host.serial_poll(r);
        chk("first poll", 16'h0048, r);
        host.serial_poll(r);
        chk("second poll", 16'h0048, r);
        rc(GQ, FE, 16'h0001, "event kept by polls");
        chk("byte after clear", 16'h0000, sb);
    endtask
    task automatic t_collide();
        @(posedge clock_i);
        q_c <= 16'h0005;
        cv <= 1'b1;
        cw <= 1'b0;
        grp <= GQ;
        fld <= FE;
        @(posedge clock_i) cv <= 1'b0;
        tick(2);
        rc(GQ, FE, 16'h0004, "event beside clear");
    endtask
    task automatic t_std();
        cmd(1'b1, GS, FN, 16'h0024);
        rc(GS, FN, 16'h0024, "std enable");
        rc(GE, FC, 16'h0008, "request enable");
        cmd(1'b1, GS, FE, 16'h00FF);
        chk("refused write", 16'h0000, sb);
        @(posedge clock_i) sev <= 8'hFF;
        @(posedge clock_i) sev <= 8'h00;
        tick(1);
        chk("std summary", 16'h0020, sb);
        rc(GS, FE, 16'h00BD, "std events");
        chk("std cleared", 16'h0000, sb);
    endtask
    task automatic t_operation_summary();
        cmd(1'b1, GO, FN, 16'hFFFF);
        @(posedge clock_i) op_c <= 16'hFFFF;
        tick(3);
        chk("operation_summary summary", 16'h0080, sb);
        rc(GO, FC, 16'h1720, "operation_summary condition");
        rc(GO, FE, 16'h1720, "operation_summary events");
        @(posedge clock_i) chan <= 2'h1;
        cmd(1'b1, GC, FN, 16'h0001);
        cmd(1'b1, GI, FN, 16'h0002);
        @(posedge clock_i) ch_c[31:16] <= 16'h0001;
        tick(6);
        // The instrument condition is the live channel summary, so it is
        // read before the channel event read clears that summary.
        rc(GI, FC, 16'h0002, "instrument condition");
        rc(GC, FE, 16'h0001, "channel events");
        rc(GO, FE, 16'h2000, "instrument summary");
    endtask
    task automatic t_live();
        @(posedge clock_i);
        qne <= 1'b1;
        rav <= 1'b1;
        #1;
        chk("live bits", 16'h0014, sb);
    endtask

    // The verdict is given here only.
    task automatic final_report();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Clock at 50 ns; a watchdog cuts a hang short.
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end
    initial begin
        repeat (3000) @(posedge clock_i);
        n_errors++;
        final_report();
    end

    // Inputs idle at time zero; reset is held for five cycles.
    initial begin
        {sys_rst_i, qne, rav, cv, cw, chan} = 7'h40;
        {op_c, q_c, wd, ch_c, sev} = 120'h0;
        grp = GO;
        fld = FE;
        n_errors = 0;
        checks_done = 0;
        repeat (5) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        #1;
        chk("byte after reset", 16'h0000, sb);
        t_filters();
        t_service();
        t_collide();
        t_std();
        t_operation_summary();
        t_live();
        final_report();
    end
endmodule
`default_nettype wire
